// ===== hw/bnp_pkg.sv
package bnp_pkg;

	localparam int NUM_GROUPS = 2;
	localparam int GROUP_W    = 4;
	localparam int PIN_W      = 8;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 32;
	localparam int IDX_W      = 10;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_LOW_DATA  = 10'h2ED;
	localparam logic [IDX_W-1:0] IDX_LOW_DIR   = 10'h2EE;
	localparam logic [IDX_W-1:0] IDX_HIGH_DATA = 10'h2FD;
	localparam logic [IDX_W-1:0] IDX_HIGH_DIR  = 10'h2FE;

	localparam int          DIR_BIT     = 0;
	localparam logic        DIR_RESET   = 1'h0;
	localparam logic [3:0]  LATCH_RESET = 4'h0;

	// pull-down window in half cycles of the core clock, rounded up to cycles
	localparam int          PD_HALF_CYCLES = 3;
	localparam int          PD_CYCLES      = (PD_HALF_CYCLES + 1) / 2;
	localparam int          SYNC_STAGES    = 2;
	localparam logic [1:0]  PD_LAST        = 2'(PD_CYCLES - 1);
	localparam logic [1:0]  SYNC_LAST      = 2'(SYNC_STAGES - 1);

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	typedef struct packed {
		logic       hit;
		logic       is_dir;
		logic       grp;
	} bnp_decode_s;

	typedef struct packed {
		logic       dir;
		logic [3:0] latch;
	} bnp_group_s;

	typedef enum {RD_IDLE, RD_PULL, RD_SETTLE, RD_RESP} bnp_rd_e;

	function automatic bnp_decode_s bnp_decode(input logic [ADDR_W-1:0] addr);
		bnp_decode_s d;
		logic [IDX_W-1:0] idx;
		idx      = addr[ADDR_W-1:2];
		d.hit    = (addr[1:0] == 2'h0) && (idx == IDX_LOW_DATA || idx == IDX_LOW_DIR
			|| idx == IDX_HIGH_DATA || idx == IDX_HIGH_DIR);
		d.is_dir = (idx == IDX_LOW_DIR) || (idx == IDX_HIGH_DIR);
		d.grp    = (idx == IDX_HIGH_DATA) || (idx == IDX_HIGH_DIR);
		return d;
	endfunction : bnp_decode

endpackage : bnp_pkg

// ===== hw/bnp_sync.sv
`timescale 1ns/10ps
module bnp_sync
	import bnp_pkg::*;
(
	input  wire logic             clk,   // core clock
	input  wire logic             rst,   // synchronous reset
	input  wire logic [PIN_W-1:0] d,     // asynchronous pin levels
	output logic      [PIN_W-1:0] q      // synchronised levels
);

	logic [PIN_W-1:0] meta_reg;
	logic [PIN_W-1:0] sync_reg;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;

endmodule : bnp_sync

// ===== hw/bnp_io_port.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module bnp_io_port
	import bnp_pkg::*;
(
	input  wire logic              CORE_CLK,   // 40 MHz core clock
	input  wire logic              RESET,      // synchronous, active high
	input  wire logic [ADDR_W-1:0] AWADDR,     // write address
	input  wire logic              AWVALID,    // write address valid
	output logic                   AWREADY,    // write address ready
	input  wire logic [DATA_W-1:0] WDATA,      // write data
	input  wire logic [3:0]        WSTRB,      // write byte strobes
	input  wire logic              WVALID,     // write data valid
	output logic                   WREADY,     // write data ready
	output logic [1:0]             BRESP,      // write response
	output logic                   BVALID,     // write response valid
	input  wire logic              BREADY,     // write response ready
	input  wire logic [ADDR_W-1:0] ARADDR,     // read address
	input  wire logic              ARVALID,    // read address valid
	output logic                   ARREADY,    // read address ready
	output logic [DATA_W-1:0]      RDATA,      // read data
	output logic [1:0]             RRESP,      // read response
	output logic                   RVALID,     // read data valid
	input  wire logic              RREADY,     // read data ready
	input  wire logic [PIN_W-1:0]  PIN_IN,     // pin levels from the pads
	output logic      [PIN_W-1:0]  PIN_OUT,    // pin drive values
	output logic      [PIN_W-1:0]  PIN_OE,     // pin drive enables
	output logic [NUM_GROUPS-1:0]  PULL_DOWN   // pull-down enable per group
);

	bnp_group_s        group_reg [NUM_GROUPS];
	bnp_group_s        group_next [NUM_GROUPS];

	logic              awready_reg;
	logic              wready_reg;
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [3:0]        wdata_reg;
	logic              wstrb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;

	logic              arready_reg;
	logic              rvalid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [1:0]        rresp_reg;
	logic [1:0]        rresp_next;
	bnp_rd_e           rd_state_reg;
	bnp_rd_e           rd_state_next;
	logic [1:0]        cnt_reg;
	logic [1:0]        cnt_next;
	logic              rd_grp_reg;
	logic [NUM_GROUPS-1:0] pull_reg;
	logic [NUM_GROUPS-1:0] pull_next;

	logic [PIN_W-1:0]  pins_sync;

	// register value in the low bits of a bus word; unused bits read 0
	function automatic logic [DATA_W-1:0] bnp_word_of(input logic [GROUP_W-1:0] v);
		return {{(DATA_W-GROUP_W){1'h0}}, v};
	endfunction : bnp_word_of

	// pin synchroniser: pads change at any time,
	// so only the second flop's output is read;
	// its two cycles of lag are covered by the settle state

	bnp_sync u_sync (
		.clk (CORE_CLK),
		.rst (RESET),
		.d   (PIN_IN),
		.q   (pins_sync)
	);

	// write channel: address and data in either order;
	// one write outstanding, readies drop until the
	// response is taken, so no payload is overwritten

	wire aw_hs = AWVALID && awready_reg;
	wire w_hs  = WVALID && wready_reg;

	// both halves present and no response pending
	wire         wr_go        = aw_held_reg && w_held_reg && !bvalid_reg;
	bnp_decode_s wr_dec;
	assign       wr_dec       = bnp_decode(awaddr_reg);

	wire aw_held_next = aw_held_reg ? !wr_go : aw_hs;
	wire w_held_next  = w_held_reg ? !wr_go : w_hs;
	wire bvalid_next  = bvalid_reg ? !BREADY : wr_go;

	// one write at a time: ready returns after the response is taken
	wire awready_next = !aw_held_next && !bvalid_next && !wr_go;
	wire wready_next  = !w_held_next && !bvalid_next && !wr_go;

	wire [1:0] wr_resp    = wr_dec.hit ? RESP_OKAY : RESP_DECERR;
	wire [1:0] bresp_next = wr_go ? wr_resp : bresp_reg;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			awready_reg <= 1'h0;
			wready_reg  <= 1'h0;
			aw_held_reg <= 1'h0;
			w_held_reg  <= 1'h0;
		end else begin
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			bvalid_reg <= 1'h0;
			bresp_reg  <= RESP_OKAY;
		end else begin
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
		end
	end

	// payload holders need no reset; qualified by the held flags
	always_ff @(posedge CORE_CLK) begin
		if (aw_hs) begin
			awaddr_reg <= AWADDR;
		end
		if (w_hs) begin
			wdata_reg <= WDATA[GROUP_W-1:0];
			wstrb_reg <= WSTRB[0];
		end
	end

	// port groups: latch written in either mode,
	// so software can preload data before turning
	// the group around, with no stale level on the pins

	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : gen_group
			wire hit_grp  = wr_go && wr_dec.hit && (wr_dec.grp == 1'(g));
			// direction bit 0 of the group's control word
			wire sel_dir  = hit_grp && wr_dec.is_dir;
			wire sel_data = hit_grp && !wr_dec.is_dir;
			// lane 0 carries both fields; other lanes ignored
			wire dir_we   = sel_dir && wstrb_reg;
			wire data_we  = sel_data && wstrb_reg;

			// direction holds the last value written
			assign group_next[g].dir = dir_we ? wdata_reg[DIR_BIT] : group_reg[g].dir;
			assign group_next[g].latch = data_we ? wdata_reg : group_reg[g].latch;

			always_ff @(posedge CORE_CLK) begin
				if (RESET) begin
					group_reg[g].dir   <= DIR_RESET;
					group_reg[g].latch <= LATCH_RESET;
				end else begin
					group_reg[g] <= group_next[g];
				end
			end

			// released pins when direction is 0
			// drive latch when direction is 1
			assign PIN_OE[g*GROUP_W +: GROUP_W]  = {GROUP_W{group_reg[g].dir}};
			// four pins share one direction bit
			assign PIN_OUT[g*GROUP_W +: GROUP_W] = group_reg[g].latch;
		end
	endgenerate

	// read channel: data reads run the pull-down window,
	// then wait out the synchroniser before sampling;
	// control and unmapped reads answer at once

	wire         ar_hs = ARVALID && arready_reg;
	bnp_decode_s rd_dec;
	assign       rd_dec = bnp_decode(ARADDR);

	wire         rd_grp_next = ar_hs ? rd_dec.grp : rd_grp_reg;
	wire         ar_dir_val  = group_reg[rd_dec.grp].dir;
	// direction read back; unmapped reads return 0
	wire [GROUP_W-1:0] dir_field = {{(GROUP_W-1){1'h0}}, ar_dir_val};
	wire [DATA_W-1:0]  dir_word  = rd_dec.hit ? bnp_word_of(dir_field) : '0;
	wire [1:0]         ar_resp   = rd_dec.hit ? RESP_OKAY : RESP_DECERR;
	wire [GROUP_W-1:0] pin_group = pins_sync[rd_grp_reg*GROUP_W +: GROUP_W];
	wire [DATA_W-1:0]  pin_word  = bnp_word_of(pin_group);

	always_comb begin
		rd_state_next = rd_state_reg;
		cnt_next      = cnt_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		case (rd_state_reg)
			RD_IDLE: begin
				if (ar_hs) begin
					cnt_next = 2'h0;
					if (rd_dec.hit && !rd_dec.is_dir) begin
						rd_state_next = RD_PULL;
					end else begin
						rd_state_next = RD_RESP;
						rdata_next    = dir_word;
						rresp_next    = ar_resp;
					end
				end
			end
			RD_PULL: begin
				if (cnt_reg == PD_LAST) begin
					cnt_next      = 2'h0;
					rd_state_next = RD_SETTLE;
				end else begin
					cnt_next = cnt_reg + 2'h1;
				end
			end
			RD_SETTLE: begin
				// wait out synchroniser latency, then sample
				if (cnt_reg == SYNC_LAST) begin
					rd_state_next = RD_RESP;
					rdata_next    = pin_word;
					rresp_next    = RESP_OKAY;
				end else begin
					cnt_next = cnt_reg + 2'h1;
				end
			end
			RD_RESP: begin
				if (RREADY) begin
					rd_state_next = RD_IDLE;
				end
			end
			default: begin
				rd_state_next = RD_IDLE;
			end
		endcase
	end

	wire arready_next = (rd_state_next == RD_IDLE);
	wire rvalid_next  = (rd_state_next == RD_RESP);

	// pull-down only on the group being read
	always_comb begin
		for (int i = 0; i < NUM_GROUPS; i++) begin
			pull_next[i] = (rd_state_next == RD_PULL) && (rd_grp_next == 1'(i));
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rd_state_reg <= RD_IDLE;
			cnt_reg      <= 2'h0;
			rd_grp_reg   <= 1'h0;
		end else begin
			rd_state_reg <= rd_state_next;
			cnt_reg      <= cnt_next;
			rd_grp_reg   <= rd_grp_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			arready_reg <= 1'h0;
			rvalid_reg  <= 1'h0;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else begin
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pull_reg <= '0;
		end else begin
			pull_reg <= pull_next;
		end
	end

	// outputs: every port below comes straight
	// from a register, with no logic after the flops

	assign AWREADY   = awready_reg;
	assign WREADY    = wready_reg;
	assign BVALID    = bvalid_reg;
	assign BRESP     = bresp_reg;
	assign ARREADY   = arready_reg;
	assign RVALID    = rvalid_reg;
	assign RDATA     = rdata_reg;
	assign RRESP     = rresp_reg;
	assign PULL_DOWN = pull_reg;

endmodule : bnp_io_port

// ===== verif/bnp_io_port_asserts.sv
`timescale 1ns/10ps
module bnp_io_port_asserts
	import bnp_pkg::*;
(
	input wire logic              CORE_CLK,   // core clock
	input wire logic              RESET,      // sync reset
	input wire logic [ADDR_W-1:0] AWADDR,     // write address
	input wire logic              AWVALID,    // aw valid
	input wire logic              AWREADY,    // aw ready
	input wire logic [DATA_W-1:0] WDATA,      // write data
	input wire logic [3:0]        WSTRB,      // strobes
	input wire logic              WVALID,     // w valid
	input wire logic              WREADY,     // w ready
	input wire logic [1:0]        BRESP,      // write response
	input wire logic              BVALID,     // b valid
	input wire logic [ADDR_W-1:0] ARADDR,     // read address
	input wire logic              ARVALID,    // ar valid
	input wire logic              ARREADY,    // ar ready
	input wire logic [DATA_W-1:0] RDATA,      // read data
	input wire logic              RVALID,     // r valid
	input wire logic [PIN_W-1:0]  PIN_OUT,    // pin drive values
	input wire logic [PIN_W-1:0]  PIN_OE,     // pin enables
	input wire logic [1:0]        PULL_DOWN   // pull-downs
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	localparam logic [11:0] A_LDAT = {IDX_LOW_DATA, 2'h0};
	localparam logic [11:0] A_LDIR = {IDX_LOW_DIR, 2'h0};
	localparam logic [11:0] A_HDAT = {IDX_HIGH_DATA, 2'h0};
	wire rd_hdat = ARVALID && ARREADY && ARADDR == A_HDAT;
	sequence s_wr(logic [11:0] a);
		AWVALID && AWREADY && WVALID && WREADY && WSTRB[0] && AWADDR == a;
	endsequence
	sequence s_rd(logic [11:0] a);
		ARVALID && ARREADY && ARADDR == a;
	endsequence
	AST_OE_GROUP: assert property (
		PIN_OE[3:0] inside {4'h0, 4'hF} && PIN_OE[7:4] inside {4'h0, 4'hF})
		else $error("pin enables split inside a group");
	AST_RST_INPUT: assert property ($fell(RESET) |-> PIN_OE == 8'h00)
		else $error("pins driven after reset");
	AST_DIR_WR: assert property (
		s_wr(A_LDIR) |-> ##2 PIN_OE[3:0] == {4{$past(WDATA[0], 2)}})
		else $error("low group enables do not follow direction write");
	AST_LATCH_WR: assert property (
		s_wr(A_LDAT) |-> ##2 PIN_OUT[3:0] == $past(WDATA[3:0], 2))
		else $error("low group latch not updated");
	AST_PULL_LEN: assert property (
		s_rd(A_LDAT) |-> ##1 PULL_DOWN[0] [*2] ##1 !PULL_DOWN[0])
		else $error("pull-down window wrong length");
	AST_PULL_CAUSE: assert property ($rose(PULL_DOWN[1]) |-> $past(rd_hdat))
		else $error("pull-down without a data read");
	AST_RD_LAT: assert property (
		s_rd(A_LDAT) |-> ##1 !RVALID [*4] ##1 RVALID)
		else $error("data read answered at wrong time");
	AST_DIR_RB: assert property (
		s_rd(A_LDIR) |-> ##1 RVALID && RDATA == {31'h0, PIN_OE[0]})
		else $error("direction readback wrong");
	AST_DECERR: assert property (
		s_wr(12'h000) |-> ##2 BVALID && BRESP == RESP_DECERR)
		else $error("unmapped write not refused");
endmodule : bnp_io_port_asserts

bind bnp_io_port bnp_io_port_asserts u_chk (.*);

// ===== verif/bnp_pad_model.sv
`timescale 1ns/10ps
module bnp_pad_model
	import bnp_pkg::*;
(
	input  wire logic             clk,        // core clock
	input  wire logic [PIN_W-1:0] pin_out,    // device drive values
	input  wire logic [PIN_W-1:0] pin_oe,     // device drive enables
	input  wire logic [1:0]       pull_down,  // pull-down per group
	input  wire logic [PIN_W-1:0] ext_en,     // board drives pin
	input  wire logic [PIN_W-1:0] ext_val,    // board drive level
	output logic      [PIN_W-1:0] pin_in      // resolved pad level
);
	// open pad with no pull wanders; only the pull-down makes it readable
	logic [PIN_W-1:0] float_q = 8'h5A;
	wire  [PIN_W-1:0] pd = {{GROUP_W{pull_down[1]}}, {GROUP_W{pull_down[0]}}};
	always @(posedge clk) float_q <= ~float_q;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & ~pd & float_q);
endmodule : bnp_pad_model

// ===== verif/bnp_io_port_tb.sv
`timescale 1ns/10ps
module bnp_io_port_tb
	import bnp_pkg::*;
;
	logic        CORE_CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0]  WSTRB, lat [2];
	logic [1:0]  BRESP, RRESP, PULL_DOWN, rs;
	logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, ext_en, ext_val;
	logic        dir [2];
	int          n_errors, checked, g;
	bnp_io_port u_dut (.*);
	bnp_pad_model u_pad (.clk(CORE_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
		.pull_down(PULL_DOWN), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN));
	function automatic logic [11:0] adr(input int grp, input logic d);
		return {grp ? (d ? IDX_HIGH_DIR : IDX_HIGH_DATA) : (d ? IDX_LOW_DIR : IDX_LOW_DATA), 2'h0};
	endfunction : adr
	// open pins read low because the pull-down is on when sampled
	function automatic logic [3:0] exp_pins(input int grp);
		return dir[grp] ? lat[grp] : ext_en[grp*4+:4] & ext_val[grp*4+:4];
	endfunction : exp_pins
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge CORE_CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 1'b0;
	endtask : wr
	task automatic rdt(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge CORE_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
	endtask : rdt
	task automatic set_dir(input int grp, input logic d);
		if (d) ext_en[grp*4+:4] <= 4'h0;
		dir[grp] = d;
		wr(adr(grp, 1'b1), {31'h0, d}, rs);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
		chk("oe", {{4{dir[1]}}, {4{dir[0]}}}, PIN_OE);
		rdt(adr(grp, 1'b1), rd, rs);
		chk("dir", {31'h0, d}, rd);
	endtask : set_dir
	task automatic rd_grp(input int grp);
		// two reads per group; only the second result is checked
		repeat (2) rdt(adr(grp, 1'b0), rd, rs);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
		chk("pins", {28'h0, exp_pins(grp)}, rd);
	endtask : rd_grp
	task automatic give_verdict;
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_errors++;
		give_verdict();
	end
	initial begin
		{RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
		{AWADDR, ARADDR, WDATA, ext_en, ext_val} = '0;
		WSTRB = 4'hF;
		void'($urandom(32'hB419));
		repeat (8) @(posedge CORE_CLK);
		RESET <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			if (k != 0) begin
				RESET <= 1'b1;
				repeat (2) @(posedge CORE_CLK);
				RESET <= 1'b0;
			end
			@(posedge CORE_CLK);
			chk("oe_rst", 8'h00, PIN_OE);
			for (g = 0; g < 2; g++) begin
				dir[g] = 1'b0;
				lat[g] = 4'h0;
				rdt(adr(g, 1'b1), rd, rs);
				chk("dir_rst", 32'h0, rd);
			end
			if (k == 0) begin
				for (g = 0; g < 2; g++) begin
					ext_en[g*4+:4] <= 4'hF;
					ext_val[g*4+:4] <= 4'h5;
					lat[g] = 4'hA;
					wr(adr(g, 1'b0), 32'hA, rs);
					rd_grp(g);
					set_dir(g, 1'b1);
					chk("out", {28'h0, lat[g]}, {28'h0, PIN_OUT[g*4+:4]});
					rd_grp(g);
					set_dir(g, 1'b0);
					ext_en[g*4+:4] <= 4'h0;
					rd_grp(g);
				end
				wr(12'h000, 32'h1, rs);
				chk("decerr_w", 32'h3, {30'h0, rs});
				rdt(12'hBB5, rd, rs);
				chk("decerr_r", 32'h3, {30'h0, rs});
			end
			if (k == 1) begin
				repeat (30) begin
					g = $urandom_range(1, 0);
					case ($urandom_range(2, 0))
						0: begin
							rd = $urandom;
							lat[g] = rd[3:0];
							wr(adr(g, 1'b0), rd, rs);
						end
						1: set_dir(g, 1'($urandom));
						default: begin
							if (!dir[g]) begin
								ext_en[g*4+:4] <= 4'($urandom);
								ext_val[g*4+:4] <= 4'($urandom);
							end
						end
					endcase
					rd_grp(g);
				end
			end
		end
		give_verdict();
	end
endmodule : bnp_io_port_tb
